/* File: design/fsp_core.sv */
// flash self-program sequencer: pointer, latch, key lock, self-timed cycles
// assumes the cpu issues table ops and register accesses on clk_sys and
// the flash array samples its command one edge after it is shown
//
// Chosen here: the plain strobed port and the placing of the registers.
module fsp_core #(
    parameter int HOLD_N       = fsp_pkg::FSP_HOLD_N,
    parameter int PROG_TIME_NS = fsp_pkg::FSP_PROG_TIME_NS
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst_n,
    input  wire logic                          por_n,
    input  wire logic [2:0]                    bus_addr,
    input  wire logic [7:0]                    bus_wdata,
    input  wire logic                          bus_wr,
    input  wire logic                          bus_rd,
    output logic [7:0]                         bus_rdata,
    input  wire fsp_pkg::fsp_tbl_req_t         tbl_req,
    output logic                               tbl_busy,
    output logic                               cpu_stall,
    output fsp_pkg::fsp_arr_cmd_t              arr_cmd,
    input  wire logic [15:0]                   arr_rdata,
    output logic [HOLD_N-1:0][7:0]             hold_data,
    output logic [HOLD_N-1:0]                  hold_keep,
    output logic                               nvm_done_irq_flag
);
    // ********************************
    // derived sizes
    // ********************************
    localparam int PW       = fsp_pkg::FSP_PTR_W;
    localparam int IDX_W    = $clog2(HOLD_N);
    localparam int PROG_RAW = (PROG_TIME_NS * fsp_pkg::FSP_CLK_MHZ + 999) / 1000;
    localparam int PROG_CYC = (PROG_RAW < 1) ? 1 : PROG_RAW;
    localparam int CNT_W    = $clog2(PROG_CYC + 1);
    localparam logic [PW-1:0] BLK_MASK = ~PW'(HOLD_N - 1);

    typedef struct packed {
        fsp_pkg::fsp_state_t   st;
        fsp_pkg::fsp_key_t     key;
        logic [PW-1:0]         ptr;
        logic [7:0]            latch;
        logic                  byte_sel;
        logic                  space;
        logic                  cfg;
        logic                  erase_sel;
        logic                  permit;
        logic                  start;
        logic                  abort_flag;
        logic                  erase_run;
        logic                  done_flag;
        logic [CNT_W-1:0]      cnt;
        logic [7:0]            rdata;
        fsp_pkg::fsp_arr_cmd_t arr;
        logic                  busy;
        logic                  stall;
    } fsp_core_t;

    localparam fsp_core_t CORE_RST = '{
        st:         fsp_pkg::FSP_ST_IDLE,
        key:        fsp_pkg::FSP_KEY_IDLE,
        ptr:        '0,
        latch:      8'h00,
        byte_sel:   1'b0,
        space:      1'b0,
        cfg:        1'b0,
        erase_sel:  1'b0,
        permit:     1'b0,
        start:      1'b0,
        abort_flag: 1'b0,
        erase_run:  1'b0,
        done_flag:  1'b0,
        cnt:        '0,
        rdata:      8'h00,
        arr:        '0,
        busy:       1'b0,
        stall:      1'b0
    };

    fsp_core_t                 s;
    fsp_core_t                 next_s;
    logic [PW-1:0]             step_eff;
    logic [PW-1:0]             step_ptr;
    logic                      bank_wr;
    logic                      bank_clr;
    logic                      launch_ok;
    logic                      keep_abort;

    // ********************************
    // pointer update and holding bank
    // ********************************
    fsp_ptr_step u_step (
        .ptr      (s.ptr),
        .mode     (tbl_req.mode),
        .eff      (step_eff),
        .next_ptr (step_ptr)
    );

    fsp_hold_bank #(
        .HOLD_N (HOLD_N)
    ) u_bank (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .wr_en     (bank_wr),
        .wr_idx    (step_eff[IDX_W-1:0]),
        .wr_data   (s.latch),
        .clr       (bank_clr),
        .hold_data (hold_data),
        .hold_keep (hold_keep)
    );

    // ********************************
    // next-state logic
    // ********************************
    // only program space is handled here; a start with the key armed but a
    // bad mode counts as an improper attempt and is refused
    assign launch_ok = (s.key == fsp_pkg::FSP_KEY_ARMED) && bus_wdata[fsp_pkg::FSP_B_PERMIT]
                       && bus_wdata[fsp_pkg::FSP_B_SPACE] && !bus_wdata[fsp_pkg::FSP_B_CFG]
                       && (s.st == fsp_pkg::FSP_ST_IDLE);

    always_comb begin
        next_s            = s;
        next_s.arr.rd_en  = 1'b0;
        next_s.arr.prog_go  = 1'b0;
        next_s.arr.erase_go = 1'b0;
        next_s.rdata      = 8'h00;
        bank_wr           = 1'b0;
        bank_clr          = 1'b0;
        keep_abort        = 1'b0;

        if (bus_rd) begin
            case (bus_addr)
                fsp_pkg::FSP_A_PTR_LO: next_s.rdata = s.ptr[7:0];
                fsp_pkg::FSP_A_PTR_HI: next_s.rdata = s.ptr[15:8];
                fsp_pkg::FSP_A_PTR_UP: next_s.rdata = {2'h0, s.ptr[PW-1:16]};
                fsp_pkg::FSP_A_LATCH:  next_s.rdata = s.latch;
                fsp_pkg::FSP_A_CTRL: begin
                    next_s.rdata = {s.space, s.cfg, 1'b0, s.erase_sel,
                                    s.abort_flag, s.permit, s.start, 1'b0};
                end
                fsp_pkg::FSP_A_STAT:   next_s.rdata = {6'h00, s.busy, s.done_flag};
                default:               next_s.rdata = 8'h00;
            endcase
        end

        if (bus_wr) begin
            // any other write between the keys and the start breaks the unlock
            if (bus_addr != fsp_pkg::FSP_A_KEY) begin
                next_s.key = fsp_pkg::FSP_KEY_IDLE;
            end
            case (bus_addr)
                fsp_pkg::FSP_A_PTR_LO: next_s.ptr[7:0]    = bus_wdata;
                fsp_pkg::FSP_A_PTR_HI: next_s.ptr[15:8]   = bus_wdata;
                fsp_pkg::FSP_A_PTR_UP: next_s.ptr[PW-1:16] = bus_wdata[5:0];
                fsp_pkg::FSP_A_LATCH:  next_s.latch       = bus_wdata;
                fsp_pkg::FSP_A_KEY: begin
                    if (bus_wdata == fsp_pkg::FSP_KEY_FIRST) begin
                        next_s.key = fsp_pkg::FSP_KEY_HALF;
                    end else if ((bus_wdata == fsp_pkg::FSP_KEY_SECOND)
                                 && (s.key == fsp_pkg::FSP_KEY_HALF)) begin
                        next_s.key = fsp_pkg::FSP_KEY_ARMED;
                    end else begin
                        next_s.key = fsp_pkg::FSP_KEY_IDLE;
                    end
                end
                fsp_pkg::FSP_A_STAT: begin
                    if (bus_wdata[fsp_pkg::FSP_B_DONE]) begin
                        next_s.done_flag = 1'b0;
                    end
                end
                fsp_pkg::FSP_A_CTRL: begin
                    if (s.st != fsp_pkg::FSP_ST_LONG) begin
                        next_s.space     = bus_wdata[fsp_pkg::FSP_B_SPACE];
                        next_s.cfg       = bus_wdata[fsp_pkg::FSP_B_CFG];
                        next_s.erase_sel = bus_wdata[fsp_pkg::FSP_B_ERASE];
                        next_s.permit    = bus_wdata[fsp_pkg::FSP_B_PERMIT];
                        // writing zero to start never clears it
                        if (bus_wdata[fsp_pkg::FSP_B_START] && !s.start) begin
                            if (launch_ok) begin
                                next_s.start      = 1'b1;
                                next_s.abort_flag = 1'b1;
                                next_s.st         = fsp_pkg::FSP_ST_LONG;
                                next_s.stall      = 1'b1;
                                next_s.busy       = 1'b1;
                                next_s.cnt        = CNT_W'(PROG_CYC - 1);
                                next_s.arr.addr   = s.ptr & BLK_MASK;
                                if (bus_wdata[fsp_pkg::FSP_B_ERASE]) begin
                                    next_s.erase_run    = 1'b1;
                                    next_s.arr.erase_go = 1'b1;
                                end else begin
                                    next_s.erase_run   = 1'b0;
                                    next_s.arr.prog_go = 1'b1;
                                end
                            end else begin
                                next_s.start      = 1'b0;
                                next_s.abort_flag = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        case (s.st)
            fsp_pkg::FSP_ST_IDLE: begin
                if (tbl_req.valid) begin
                    next_s.ptr = step_ptr;
                    if (tbl_req.write) begin
                        bank_wr = 1'b1;
                    end else begin
                        next_s.arr.rd_en = 1'b1;
                        next_s.arr.addr  = step_eff;
                        next_s.byte_sel  = step_eff[0];
                        next_s.st        = fsp_pkg::FSP_ST_RD_ISSUE;
                        next_s.busy      = 1'b1;
                    end
                end
            end
            fsp_pkg::FSP_ST_RD_ISSUE: begin
                next_s.st = fsp_pkg::FSP_ST_RD_CAP;
            end
            fsp_pkg::FSP_ST_RD_CAP: begin
                next_s.latch = s.byte_sel ? arr_rdata[15:8] : arr_rdata[7:0];
                next_s.st    = fsp_pkg::FSP_ST_IDLE;
                next_s.busy  = 1'b0;
            end
            fsp_pkg::FSP_ST_LONG: begin
                if (s.cnt == '0) begin
                    next_s.st         = fsp_pkg::FSP_ST_IDLE;
                    next_s.start      = 1'b0;
                    next_s.stall      = 1'b0;
                    next_s.busy       = 1'b0;
                    next_s.abort_flag = 1'b0;
                    next_s.done_flag  = 1'b1;
                    next_s.erase_run  = 1'b0;
                    if (s.erase_run) begin
                        next_s.erase_sel = 1'b0;
                    end else begin
                        bank_clr = 1'b1;
                    end
                end else begin
                    next_s.cnt = s.cnt - CNT_W'(1);
                end
            end
            default: begin
                next_s.st = fsp_pkg::FSP_ST_IDLE;
            end
        endcase

        // a warm reset in the middle of a cycle leaves the abort flag up;
        // only the power-on reset or the end of a later finished cycle clears it
        if (!rst_n || !por_n) begin
            keep_abort        = (s.abort_flag || (s.st == fsp_pkg::FSP_ST_LONG)) && por_n;
            next_s            = CORE_RST;
            next_s.abort_flag = keep_abort;
        end
    end

    always_ff @(posedge clk_sys) begin
        s <= next_s;
    end

    assign bus_rdata         = s.rdata;
    assign tbl_busy          = s.busy;
    assign cpu_stall         = s.stall;
    assign arr_cmd           = s.arr;
    assign nvm_done_irq_flag = s.done_flag;

    // ********************************
    // checks
    // ********************************
    default clocking fsp_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic tbl_take;
    logic ptr_wr;
    assign tbl_take = (s.st == fsp_pkg::FSP_ST_IDLE) && tbl_req.valid;
    assign ptr_wr   = bus_wr && (bus_addr inside {fsp_pkg::FSP_A_PTR_LO,
                      fsp_pkg::FSP_A_PTR_HI, fsp_pkg::FSP_A_PTR_UP});

    // counts stall cycles; a cycle cut by reset is left out by the past reset term
    logic [CNT_W:0] stall_len;
    always_ff @(posedge clk_sys) begin
        stall_len <= cpu_stall ? stall_len + 1'b1 : '0;
    end

    ptr_top_keep_a: assert property (tbl_take && !ptr_wr |=> $stable(s.ptr[PW-1]))
        else $error("pointer top bit moved on a table op");
    post_inc_a: assert property (tbl_take && !ptr_wr
        && tbl_req.mode == fsp_pkg::FSP_PTR_POST_INC
        |=> s.ptr[PW-2:0] == $past(s.ptr[PW-2:0]) + 21'h000001)
        else $error("post increment wrong");
    rd_issue_a: assert property (tbl_take && !tbl_req.write
        |=> arr_cmd.rd_en && arr_cmd.addr == $past(step_eff) ##1 !arr_cmd.rd_en)
        else $error("table read not issued");
    latch_sel_a: assert property (s.st == fsp_pkg::FSP_ST_RD_CAP && !(bus_wr
        && bus_addr == fsp_pkg::FSP_A_LATCH) |=> s.latch == ($past(s.byte_sel)
        ? $past(arr_rdata[15:8]) : $past(arr_rdata[7:0])))
        else $error("latch byte select wrong");
    stall_hold_a: assert property ($fell(cpu_stall) && $past(rst_n && por_n)
        |-> stall_len == (CNT_W+1)'(PROG_CYC))
        else $error("stall length wrong");
    key_gate_a: assert property ($rose(s.start)
        |-> $past(s.key) == fsp_pkg::FSP_KEY_ARMED)
        else $error("start without unlock");
    block_align_a: assert property (arr_cmd.erase_go || arr_cmd.prog_go
        |-> (arr_cmd.addr & ~BLK_MASK) == '0 && s.abort_flag)
        else $error("block address not aligned");
    cycle_end_a: assert property ($fell(cpu_stall) && $past(s.erase_run)
        && $past(rst_n && por_n) |-> !s.start && !s.erase_sel && s.done_flag)
        else $error("erase end bits wrong");
    short_write_a: assert property (tbl_take && tbl_req.write
        |=> !arr_cmd.prog_go && !arr_cmd.erase_go)
        else $error("table write started long write");
    start_keep_a: assert property (s.st == fsp_pkg::FSP_ST_LONG && s.cnt != '0
        |=> s.start)
        else $error("start bit cleared early");
    done_set_a: assert property (s.st == fsp_pkg::FSP_ST_LONG && s.cnt == '0
        |=> nvm_done_irq_flag && !cpu_stall)
        else $error("done flag not set at cycle end");
    bank_clear_a: assert property (bank_clr |=> &hold_keep)
        else $error("holding bank not reset after programming");
    // a warm reset in a running cycle keeps the abort flag for tracing
    abort_keep_a: assert property (!$past(rst_n) && $past(por_n)
        && $past(s.st) == fsp_pkg::FSP_ST_LONG |-> s.abort_flag)
        else $error("abort flag lost on warm reset");

    read_path_c: cover property (tbl_take && !tbl_req.write ##3 !tbl_busy);
    erase_run_c: cover property (arr_cmd.erase_go ##[1:1000] !cpu_stall);
    prog_run_c:  cover property (arr_cmd.prog_go ##[1:1000] !cpu_stall);
    warm_cut_c:  cover property (!$past(rst_n) && s.abort_flag && !cpu_stall);
endmodule

/* File: design/fsp_pkg.sv */
// shared constants and types of the flash self-program sequencer
// assumes one core clock and a synchronous active-low reset
// Operation
// - three pointer bytes form one 22-bit pointer
// - low 21 bits address memory, top bit config
// - four pointer update modes around each transfer
// - auto update touches low 21 bits only
// - table read uses all 22 bits into latch
// - address lsb picks high or low byte
// - table write stores latch at pointer low bits
// - upper pointer bits select programmed block at start
// - erase uses upper bits, ignores low six
// - erase granule 64 or 128 bytes, never words
// - erase needs space select, permit and erase select
// - cpu stalls until the programming timer ends
// - program granule 64 or 128 bytes only
// - 64 or 128 holding registers, table writes only
// - table writes are short, start launches long write
// - holding registers FFh after reset and programming
// - FFh holding byte leaves array byte alone
// - start bit settable only, hardware clears at end
// - hardware clears erase select after erase
// - abort flag on reset mid-cycle or improper start
// - done flag set at end, software clears it
package fsp_pkg;

    // ********************************
    // sizes and timing
    // ********************************
    localparam int FSP_PTR_W        = 22;
    localparam int FSP_LOW_W        = 21;
    localparam int FSP_HOLD_N       = 64;
    localparam int FSP_CLK_MHZ      = 250;
    localparam int FSP_PROG_TIME_NS = 2000;

    // ********************************
    // register offsets and fields
    // ********************************
    localparam logic [2:0] FSP_A_PTR_LO = 3'h0;
    localparam logic [2:0] FSP_A_PTR_HI = 3'h1;
    localparam logic [2:0] FSP_A_PTR_UP = 3'h2;
    localparam logic [2:0] FSP_A_LATCH  = 3'h3;
    localparam logic [2:0] FSP_A_CTRL   = 3'h4;
    localparam logic [2:0] FSP_A_KEY    = 3'h5;
    localparam logic [2:0] FSP_A_STAT   = 3'h6;
    localparam int FSP_B_SPACE  = 7;
    localparam int FSP_B_CFG    = 6;
    localparam int FSP_B_ERASE  = 4;
    localparam int FSP_B_ABORT  = 3;
    localparam int FSP_B_PERMIT = 2;
    localparam int FSP_B_START  = 1;
    localparam int FSP_B_DONE   = 0;
    localparam int FSP_B_BUSY   = 1;
    localparam logic [7:0] FSP_KEY_FIRST  = 8'h55;
    localparam logic [7:0] FSP_KEY_SECOND = 8'hAA;
    localparam logic [7:0] FSP_HOLD_INIT  = 8'hFF;

    // ********************************
    // types
    // ********************************
    typedef enum logic [1:0] {
        FSP_PTR_KEEP     = 2'h0,
        FSP_PTR_POST_INC = 2'h1,
        FSP_PTR_POST_DEC = 2'h2,
        FSP_PTR_PRE_INC  = 2'h3
    } fsp_ptr_mode_t;

    typedef enum logic [3:0] {
        FSP_ST_IDLE     = 4'h1,
        FSP_ST_RD_ISSUE = 4'h2,
        FSP_ST_RD_CAP   = 4'h4,
        FSP_ST_LONG     = 4'h8
    } fsp_state_t;

    typedef enum logic [2:0] {
        FSP_KEY_IDLE  = 3'h1,
        FSP_KEY_HALF  = 3'h2,
        FSP_KEY_ARMED = 3'h4
    } fsp_key_t;

    typedef struct packed {
        logic          valid;
        logic          write;
        fsp_ptr_mode_t mode;
    } fsp_tbl_req_t;

    typedef struct packed {
        logic                 rd_en;
        logic                 prog_go;
        logic                 erase_go;
        logic [FSP_PTR_W-1:0] addr;
    } fsp_arr_cmd_t;

endpackage

/* File: design/fsp_ptr_step.sv */
// pointer update unit: effective address and updated pointer
// purely combinational, fed from the pointer flops of the core
module fsp_ptr_step (
    input  wire logic [fsp_pkg::FSP_PTR_W-1:0] ptr,
    input  wire fsp_pkg::fsp_ptr_mode_t        mode,
    output logic [fsp_pkg::FSP_PTR_W-1:0]      eff,
    output logic [fsp_pkg::FSP_PTR_W-1:0]      next_ptr
);
    localparam int LW = fsp_pkg::FSP_LOW_W;

    logic [LW-1:0] low_inc;
    logic [LW-1:0] low_dec;

    // low part wraps on its own, the space bit never moves
    assign low_inc = ptr[LW-1:0] + LW'(1);
    assign low_dec = ptr[LW-1:0] - LW'(1);

    always_comb begin
        eff      = ptr;
        next_ptr = ptr;
        case (mode)
            fsp_pkg::FSP_PTR_KEEP: begin
                next_ptr = ptr;
            end
            fsp_pkg::FSP_PTR_POST_INC: begin
                next_ptr = {ptr[LW], low_inc};
            end
            fsp_pkg::FSP_PTR_POST_DEC: begin
                next_ptr = {ptr[LW], low_dec};
            end
            fsp_pkg::FSP_PTR_PRE_INC: begin
                next_ptr = {ptr[LW], low_inc};
                eff      = {ptr[LW], low_inc};
            end
            default: begin
                next_ptr = ptr;
            end
        endcase
    end
endmodule

/* File: design/fsp_hold_bank.sv */
// bank of holding registers loaded by table writes
// clr is a one-cycle pulse from the core after a finished programming cycle
module fsp_hold_bank #(
    parameter int HOLD_N = fsp_pkg::FSP_HOLD_N,
    parameter int IDX_W  = $clog2(HOLD_N)
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   wr_en,
    input  wire logic [IDX_W-1:0]       wr_idx,
    input  wire logic [7:0]             wr_data,
    input  wire logic                   clr,
    output logic [HOLD_N-1:0][7:0]      hold_data,
    output logic [HOLD_N-1:0]           hold_keep
);
    typedef struct packed {
        logic [HOLD_N-1:0][7:0] bytes;
        logic [HOLD_N-1:0]      keep;
    } fsp_bank_t;

    fsp_bank_t s;
    fsp_bank_t next_s;

    always_comb begin
        next_s = s;
        for (int i = 0; i < HOLD_N; i++) begin
            if (!rst_n || clr) begin
                next_s.bytes[i] = fsp_pkg::FSP_HOLD_INIT;
                next_s.keep[i]  = 1'b1;
            end else if (wr_en && (wr_idx == IDX_W'(i))) begin
                next_s.bytes[i] = wr_data;
                // an erased-value byte tells the array to leave that byte alone
                next_s.keep[i]  = (wr_data == fsp_pkg::FSP_HOLD_INIT);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        s <= next_s;
    end

    assign hold_data = s.bytes;
    assign hold_keep = s.keep;
endmodule

/* File: testbench/fsp_flash_model.sv */
// flash array model: answers byte-address reads one cycle after rd_en
// assumes the sequencer samples the word only in the cycle after rd_en
module fsp_flash_model (
    input  wire logic                  clk_sys,
    input  wire fsp_pkg::fsp_arr_cmd_t arr_cmd,
    output logic [15:0]                arr_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************
    // read port
    // ********************************
    // word content: low byte = word address, high byte = that xor A5;
    // outside the answer cycle the word toggles so stale data never matches
    always @(posedge clk_sys) begin
        if (arr_cmd.rd_en === 1'b1) begin
            arr_rdata <= {arr_cmd.addr[8:1] ^ 8'hA5, arr_cmd.addr[8:1]};
        end else begin
            arr_rdata <= ~arr_rdata;
        end
    end
endmodule

/* File: testbench/tb.sv */
// self-checking bench of the sequencer core with a flash array model
// assumes a short programming time so each long cycle is a few clocks
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk_sys;
    logic                  rst_n;
    logic                  por_n;
    logic [2:0]            bus_addr;
    logic [7:0]            bus_wdata;
    logic                  bus_wr;
    logic                  bus_rd;
    logic [7:0]            bus_rdata;
    fsp_pkg::fsp_tbl_req_t tbl_req;
    logic                  tbl_busy;
    logic                  cpu_stall;
    fsp_pkg::fsp_arr_cmd_t arr_cmd;
    logic [15:0]           arr_rdata;
    logic [63:0][7:0]      hold_data;
    logic [63:0]           hold_keep;
    logic                  done_flag;
    logic [21:0]           rd_addr;
    logic [21:0]           go_addr;
    logic                  go_prog;
    logic [7:0]            d;
    int                    failures = 0;
    int                    checks = 0;
    int                    go_cnt = 0;

    fsp_core #(.HOLD_N(64), .PROG_TIME_NS(20)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .tbl_req(tbl_req), .tbl_busy(tbl_busy), .cpu_stall(cpu_stall), .arr_cmd(arr_cmd),
        .arr_rdata(arr_rdata), .hold_data(hold_data), .hold_keep(hold_keep),
        .nvm_done_irq_flag(done_flag));
    fsp_flash_model model (.clk_sys(clk_sys), .arr_cmd(arr_cmd), .arr_rdata(arr_rdata));

    always @(posedge clk_sys) begin
        if (arr_cmd.rd_en === 1'b1) begin
            rd_addr <= arr_cmd.addr;
        end
        if (arr_cmd.prog_go === 1'b1 || arr_cmd.erase_go === 1'b1) begin
            go_addr <= arr_cmd.addr;
            go_prog <= arr_cmd.prog_go;
            go_cnt <= go_cnt + 1;
        end
    end

    // ********************************
    // tasks
    // ********************************
    task automatic complete_run();
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // strobes stay up until the next task sets them, so calls chain with no gap
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        bus_wr <= 1'b1;
        bus_rd <= 1'b0;
        bus_addr <= a;
        bus_wdata <= v;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        bus_rd <= 1'b1;
        bus_wr <= 1'b0;
        bus_addr <= a;
        @(posedge clk_sys);
        #1 v = bus_rdata;
    endtask
    task automatic idle();
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        tbl_req <= '0;
        @(posedge clk_sys);
    endtask
    task automatic op(input logic w, input fsp_pkg::fsp_ptr_mode_t m);
        tbl_req <= '{valid: 1'b1, write: w, mode: m};
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wait_idle();
        idle();
        for (int i = 0; i < 40; i++) begin
            #1;
            if (tbl_busy === 1'b0) return;
            @(posedge clk_sys);
        end
        failures++;
        complete_run();
    endtask
    task automatic set_ptr(input logic [21:0] p);
        wr(3'h0, p[7:0]);
        wr(3'h1, p[15:8]);
        wr(3'h2, {2'h0, p[21:16]});
    endtask
    task automatic chk_ptr(input logic [21:0] p);
        logic [7:0] lo, hi, up;
        rd(3'h0, lo);
        rd(3'h1, hi);
        rd(3'h2, up);
        chk({up, hi, lo}, {2'h0, p});
    endtask
    function automatic logic [7:0] exp_byte(input logic [21:0] a);
        return a[0] ? (a[8:1] ^ 8'hA5) : a[8:1];
    endfunction
    task automatic fetch(input fsp_pkg::fsp_ptr_mode_t m, inout logic [21:0] p);
        logic [21:0] up, dn, eff;
        up = {p[21], p[20:0] + 21'h1};
        dn = {p[21], p[20:0] - 21'h1};
        eff = (m == fsp_pkg::FSP_PTR_PRE_INC) ? up : p;
        op(1'b0, m);
        wait_idle();
        chk(rd_addr, eff);
        rd(3'h3, d);
        chk(d, exp_byte(eff));
        p = (m == fsp_pkg::FSP_PTR_KEEP) ? p : (m == fsp_pkg::FSP_PTR_POST_DEC) ? dn : up;
        chk_ptr(p);
    endtask
    task automatic launch(input logic [7:0] c);
        wr(3'h5, fsp_pkg::FSP_KEY_FIRST);
        wr(3'h5, fsp_pkg::FSP_KEY_SECOND);
        wr(3'h4, c);
        idle();
        #1 chk(cpu_stall, 1'b1);
        wait_idle();
    endtask

    // ********************************
    // stimulus
    // ********************************
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        logic [21:0] p;
        rst_n = 1'b0;
        por_n = 1'b0;
        bus_addr = 3'h0;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        tbl_req = '0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        @(posedge clk_sys);
        chk(hold_keep, '1);
        p = 22'h3FFFFF;
        set_ptr(p);
        fetch(fsp_pkg::FSP_PTR_POST_INC, p);
        p = 22'h200000;
        set_ptr(p);
        fetch(fsp_pkg::FSP_PTR_POST_DEC, p);
        p = 22'h000011;
        set_ptr(p);
        for (int i = 0; i < 4; i++) begin
            fetch(fsp_pkg::fsp_ptr_mode_t'(i), p);
        end
        // two back-to-back stores, then a partial block program
        set_ptr(22'h000045);
        wr(3'h3, 8'h12);
        op(1'b1, fsp_pkg::FSP_PTR_POST_INC);
        op(1'b1, fsp_pkg::FSP_PTR_POST_INC);
        idle();
        chk(hold_data[6], 8'h12);
        chk(hold_keep[7:4], 4'h9);
        chk(go_cnt, 0);
        wr(3'h5, fsp_pkg::FSP_KEY_SECOND);
        wr(3'h5, fsp_pkg::FSP_KEY_FIRST);
        wr(3'h4, 8'h86);
        idle();
        #1 chk(cpu_stall, 1'b0);
        rd(3'h4, d);
        chk(d, 8'h8C);
        launch(8'h86);
        chk({go_prog, go_addr}, {1'b1, 22'h000040});
        chk(done_flag, 1'b1);
        rd(3'h4, d);
        chk(d, 8'h84);
        rd(3'h6, d);
        chk(d, 8'h01);
        chk(hold_keep, '1);
        wr(3'h6, 8'h01);
        rd(3'h6, d);
        chk(d, 8'h00);
        set_ptr(22'h012345);
        launch(8'h96);
        chk({go_prog, go_addr}, {1'b0, 22'h012340});
        rd(3'h4, d);
        chk(d, 8'h84);
        // warm reset one edge into a program cycle: abort flag must survive it
        wr(3'h5, fsp_pkg::FSP_KEY_FIRST);
        wr(3'h5, fsp_pkg::FSP_KEY_SECOND);
        wr(3'h4, 8'h86);
        rst_n <= 1'b0;
        idle();
        rst_n <= 1'b1;
        idle();
        rd(3'h4, d);
        chk({cpu_stall, d}, 9'h008);
        idle();
        complete_run();
    end
endmodule
